// ==== hw/qdl_pkg.sv ====
package qdl_pkg;
  localparam int WORD_W    = 24;
  localparam int CODE_W    = 16;
  localparam int NUM_CH    = 4;
  localparam int CH_W      = 2;
  // Word positions
  localparam int POS_CH_HI = 23;
  localparam int POS_CH_LO = 22;
  localparam int POS_QUICK = 21;
  localparam int POS_CODE  = 15;
  localparam logic [CODE_W-1:0] CODE_MID  = 16'h8000;
  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;

  typedef struct packed {
    logic              chan_sel_hi;
    logic              chan_sel_lo;
    logic              quick;
    logic [4:0]        unused;
    logic [CODE_W-1:0] code;
  } qdl_word_t;

  typedef struct packed {
    logic serial_in;
    logic clk;
    logic cs_n;
    logic load_n;
    logic update_strobe_n;
    logic rst;
    logic reset_level_select;
  } qdl_pins_t;

  // Levels the pins rest at between transfers
  localparam qdl_pins_t PINS_IDLE = '{
    serial_in:          1'b0,
    clk:                1'b1,
    cs_n:               1'b1,
    load_n:             1'b1,
    update_strobe_n:    1'b1,
    rst:                1'b0,
    reset_level_select: 1'b0
  };
endpackage

// ==== hw/qdl_sync.sv ====
`timescale 1ns/1ps
module qdl_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// ==== hw/qdl_top.sv ====
`timescale 1ns/1ps
// How it works
// - 24-bit word, MSB first, fixed field order
// - Top two bits pick input register
// - Quick-load bit writes all four registers
// - Otherwise only addressed register is written
// - Five middle bits are ignored
// - Low sixteen bits are the code
// - Input registers follow while load low
// - Output register captures on update rising edge
// - One update edge moves all four together
// - Shift clock is chip select OR clock
// - Either input may clock the shift register
// - Chip select rising with clock low shifts
// - Shifting during load corrupts selected registers
// - Reset rising edge sets midscale or zero
// - Reset leaves shift register untouched
// - Serial out is last shift stage
module qdl_top #(
  parameter int NUM_CH = qdl_pkg::NUM_CH,
  parameter int CODE_W = qdl_pkg::CODE_W,
  parameter int WORD_W = qdl_pkg::WORD_W
) (
  input  wire logic                            I_CLK,
  input  wire logic                            I_RESET,
  input  wire qdl_pkg::qdl_pins_t              I_PINS,
  output logic                                 O_SERIAL_OUT,
  output logic [NUM_CH-1:0][CODE_W-1:0]        O_DAC_CODE,
  output logic [NUM_CH-1:0][CODE_W-1:0]        O_INPUT_CODE,
  output logic [WORD_W-1:0]                    O_SHIFT_WORD
);
  if (NUM_CH != qdl_pkg::NUM_CH || CODE_W != qdl_pkg::CODE_W ||
      WORD_W != qdl_pkg::WORD_W) begin : g_chk
    $error("qdl_top: word layout is fixed at 24/16 bits, 4 channels");
  end

  // Every pin is asynchronous to I_CLK. Sync stages reset to the idle
  // levels, else a block reset would fake a load and an update edge.
  logic serial_in_s;
  logic clk_s;
  logic cs_n_s;
  logic load_n_s;
  logic upd_n_s;
  logic rst_s;
  logic rsel_s;

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.serial_in)
  ) u_sync_serial_in (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.serial_in),
    .o_sync  (serial_in_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.clk)
  ) u_sync_clk (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.clk),
    .o_sync  (clk_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.cs_n)
  ) u_sync_cs_n (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.cs_n),
    .o_sync  (cs_n_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.load_n)
  ) u_sync_load_n (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.load_n),
    .o_sync  (load_n_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.update_strobe_n)
  ) u_sync_upd_n (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.update_strobe_n),
    .o_sync  (upd_n_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.rst)
  ) u_sync_rst (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.rst),
    .o_sync  (rst_s)
  );

  qdl_sync #(
    .W       (1),
    .RST_VAL (qdl_pkg::PINS_IDLE.reset_level_select)
  ) u_sync_rsel (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_PINS.reset_level_select),
    .o_sync  (rsel_s)
  );

  qdl_pkg::qdl_pins_t pin_s;

  assign pin_s = '{
    serial_in:          serial_in_s,
    clk:                clk_s,
    cs_n:               cs_n_s,
    load_n:             load_n_s,
    update_strobe_n:    upd_n_s,
    rst:                rst_s,
    reset_level_select: rsel_s
  };

  // Delayed copies for edge detection, taken from the second stage
  logic shclk_d_ff;
  logic upd_d_ff;
  logic rst_d_ff;
  logic shclk;

  assign shclk = pin_s.cs_n | pin_s.clk;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      shclk_d_ff <= qdl_pkg::PINS_IDLE.cs_n | qdl_pkg::PINS_IDLE.clk;
      upd_d_ff   <= qdl_pkg::PINS_IDLE.update_strobe_n;
      rst_d_ff   <= qdl_pkg::PINS_IDLE.rst;
    end else begin
      shclk_d_ff <= shclk;
      upd_d_ff   <= pin_s.update_strobe_n;
      rst_d_ff   <= pin_s.rst;
    end
  end

  logic shift_evt;
  logic upd_evt;
  logic rst_evt;

  assign shift_evt = shclk & ~shclk_d_ff;
  assign upd_evt   = pin_s.update_strobe_n & ~upd_d_ff;
  assign rst_evt   = pin_s.rst & ~rst_d_ff;

  // Shift register; device reset pin deliberately not used here
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;

  assign nxt_shift = {shift_ff[WORD_W-2:0], pin_s.serial_in};

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      shift_ff <= '0;
    end else if (shift_evt) begin
      shift_ff <= nxt_shift;
    end
  end

  qdl_pkg::qdl_word_t word;
  assign word = qdl_pkg::qdl_word_t'(shift_ff);

  logic [qdl_pkg::CH_W-1:0] chan;
  assign chan = {word.chan_sel_hi, word.chan_sel_lo};

  logic [CODE_W-1:0] rst_code;
  assign rst_code = pin_s.reset_level_select ?
                    qdl_pkg::CODE_MID : qdl_pkg::CODE_ZERO;

  // Address decode; quick load selects every input register
  logic [NUM_CH-1:0] wr_sel;

  always_comb begin
    wr_sel = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (word.quick || chan == qdl_pkg::CH_W'(i)) begin
        wr_sel[i] = 1'b1;
      end
    end
  end

  // Input registers as transparent-while-low, clocked for sampling.
  // Follows the live shift word, so shifting under load corrupts.
  logic [NUM_CH-1:0][CODE_W-1:0] in_ff;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      in_ff <= {NUM_CH{qdl_pkg::CODE_MID}};
    end else if (rst_evt) begin
      in_ff <= {NUM_CH{rst_code}};
    end else if (!pin_s.load_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_sel[i]) begin
          in_ff[i] <= word.code;
        end
      end
    end
  end

  // Output registers, all captured on one update edge
  logic [NUM_CH-1:0][CODE_W-1:0] dac_ff;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      dac_ff <= {NUM_CH{qdl_pkg::CODE_MID}};
    end else if (rst_evt) begin
      dac_ff <= {NUM_CH{rst_code}};
    end else if (upd_evt) begin
      dac_ff <= in_ff;
    end
  end

  assign O_SERIAL_OUT = shift_ff[WORD_W-1];
  assign O_DAC_CODE   = dac_ff;
  assign O_INPUT_CODE = in_ff;
  assign O_SHIFT_WORD = shift_ff;
endmodule

// ==== sim/qdl_asserts.sv ====
`timescale 1ns/1ps
module qdl_asserts #(
  parameter int NUM_CH = 4,
  parameter int CODE_W = 16,
  parameter int WORD_W = 24
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire qdl_pkg::qdl_pins_t I_PINS,
  input wire logic O_SERIAL_OUT,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] O_DAC_CODE,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] O_INPUT_CODE,
  input wire logic [WORD_W-1:0] O_SHIFT_WORD
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  property p_so; O_SERIAL_OUT == O_SHIFT_WORD[WORD_W-1]; endproperty
  a_so: assert property (p_so) else $error("serial out");
  property p_sh; $rose(I_PINS.cs_n | I_PINS.clk) |-> ##3 O_SHIFT_WORD ==
    {$past(O_SHIFT_WORD[WORD_W-2:0]), $past(I_PINS.serial_in, 3)};
  endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_rs; $rose(I_PINS.rst) && I_PINS.cs_n |=>
    $stable(O_SHIFT_WORD)[*4]; endproperty
  a_rs: assert property (p_rs) else $error("shift on reset");
  property p_ld; (!I_PINS.load_n && $stable(O_SHIFT_WORD))[*4] |->
    (O_SHIFT_WORD[21] ? O_INPUT_CODE == {NUM_CH{O_SHIFT_WORD[15:0]}}
    : O_INPUT_CODE[O_SHIFT_WORD[23:22]] == O_SHIFT_WORD[15:0]); endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_ih; (I_PINS.load_n && !I_PINS.rst)[*5] |=>
    $stable(O_INPUT_CODE); endproperty
  a_ih: assert property (p_ih) else $error("input hold");
  property p_dh; (I_PINS.update_strobe_n && !I_PINS.rst)[*5] |=>
    $stable(O_DAC_CODE); endproperty
  a_dh: assert property (p_dh) else $error("dac hold");
  property p_up; $rose(I_PINS.update_strobe_n) && I_PINS.load_n |->
    ##3 O_DAC_CODE == O_INPUT_CODE; endproperty
  a_up: assert property (p_up) else $error("update");
  property p_rt; $rose(I_PINS.rst) |-> ##3 O_DAC_CODE == O_INPUT_CODE &&
    O_DAC_CODE == {NUM_CH{I_PINS.reset_level_select ? 16'h8000 : 16'h0000}};
  endproperty
  a_rt: assert property (p_rt) else $error("reset");
endmodule
bind qdl_top qdl_asserts #(.NUM_CH(NUM_CH), .CODE_W(CODE_W),
  .WORD_W(WORD_W)) u_chk (.I_CLK, .I_RESET, .I_PINS, .O_SERIAL_OUT,
  .O_DAC_CODE, .O_INPUT_CODE, .O_SHIFT_WORD);

// ==== sim/qdl_host.sv ====
`timescale 1ns/1ps
module qdl_host (
  input wire logic           i_clk,
  output qdl_pkg::qdl_pins_t o_pins
);
  // Select idles high so no stray shift edge
  initial o_pins = qdl_pkg::PINS_IDLE;
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic send(input logic [23:0] w);
    o_pins.cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_pins.clk = 1'b0;
      o_pins.serial_in = w[i];
      wt(3);
      o_pins.clk = 1'b1;
      wt(3);
    end
    o_pins.cs_n = 1'b1;
    o_pins.serial_in = ~w[0];
    wt(3);
  endtask
  task automatic flip(input int b);
    o_pins[b] = ~o_pins[b];
    wt(6);
    o_pins[b] = ~o_pins[b];
    wt(6);
  endtask
endmodule

// ==== sim/qdl_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module qdl_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int bad_count = 0;
  int checks_done = 0;
  qdl_pkg::qdl_pins_t pins;
  logic [3:0][15:0] dac, inp;
  logic [23:0] sw;
  logic so;
  initial forever #10 clk = ~clk;
  qdl_host i_host (.i_clk(clk), .o_pins(pins));
  qdl_top i_dut (.I_CLK(clk), .I_RESET(rst), .I_PINS(pins), .O_SERIAL_OUT(so),
    .O_DAC_CODE(dac), .O_INPUT_CODE(inp), .O_SHIFT_WORD(sw));
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_load;
    i_host.send(24'hb5beef);
    i_host.flip(3);
    `CHK(inp, {4{16'hbeef}})
    `CHK(dac, {4{16'h8000}})
    for (int c = 0; c < 4; c++) begin
      i_host.send({c[1:0], 6'h1f, 16'h1000 + c[15:0]});
      i_host.flip(3);
    end
    `CHK(inp, 64'h1003100210011000)
    `CHK(sw, 24'hdf1003)
    `CHK(so, 1'b1)
    i_host.flip(2);
    `CHK(dac, 64'h1003100210011000)
  endtask
  task automatic t_rst;
    i_host.flip(1);
    `CHK({dac, inp}, 128'h0)
    `CHK(sw, 24'hdf1003)
    i_host.o_pins.reset_level_select = 1'b1;
    i_host.flip(1);
    `CHK({dac, inp}, {8{16'h8000}})
  endtask
  task automatic t_cs;
    i_host.o_pins.serial_in = 1'b1;
    i_host.o_pins.clk = 1'b0;
    i_host.flip(4);
    `CHK(sw, 24'hbe2007)
    `CHK(so, 1'b1)
    i_host.o_pins.load_n = 1'b0;
    i_host.flip(4);
    `CHK(inp, {4{16'h400f}})
    `CHK(so, 1'b0)
    i_host.o_pins.load_n = 1'b1;
    i_host.wt(3);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #2 rst = 1'b0;
    i_host.wt(3);
    t_load;
    t_rst;
    t_cs;
    give_verdict;
  end
endmodule
